// ### src/system_misc_control.sv
// file: system control register with AXI4-Lite slave and external access stretcher
//
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

// Operation
// - written value takes effect next cycle
// - normal modes write once, special anytime
// - stretch field adds 0..3 bus cycles
// - stretch ignored in single-chip, peripheral
// - high-half-only blocks low fixed pages
// - clear high-half-only allows low pages
// - enable bit maps program memory in
// - enable reset value set by mode, parameter
// - readable always, per-field write permission
// - timing clock high phase stretched
module system_misc_control #(
    parameter logic pmen_rst_normal = 1'b1,
    parameter logic pmen_rst_test   = 1'b0
) (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // mode pins, sampled at reset release
    input  wire logic [2:0]  mode_pins,
    // axi4-lite write
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // memory map decode
    input  wire logic        low_fixed_page_hit,
    output logic             program_mem_visible,
    output logic             low_fixed_page_enable,
    // external access timing
    output logic             ext_access_busy,
    output logic             bus_timing_clock
);

    // ====================================================================
    // mode capture
    logic [2:0]                  mode_s1_q;
    logic [2:0]                  mode_s2_q;
    logic                        rst_seen_q;
    misc_ctrl_pkg::op_mode_t     mode_q;

    always_ff @(posedge aclk) begin
        mode_s1_q <= mode_pins;
        mode_s2_q <= mode_s1_q;
    end

    // mode latched on the first clock after release, a strap and not a reset value
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rst_seen_q <= 1'b0;
        end else begin
            rst_seen_q <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_q <= misc_ctrl_pkg::mode_special_single;
        end else if (!rst_seen_q) begin
            mode_q <= misc_ctrl_pkg::op_mode_t'(mode_s2_q);
        end
    end

    // ====================================================================
    // axi4-lite write path
    logic        aw_held_q;
    logic        w_held_q;
    logic [3:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic        wstrb0_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        wr_fire;

    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready  = !w_held_q && !bvalid_q;
    assign wr_fire       = aw_held_q && w_held_q && !bvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            awaddr_q  <= 4'h0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_q <= 1'b0;
            wdata_q  <= 32'h0000_0000;
            wstrb0_q <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb0_q <= s_axi_wstrb[0];
        end else if (wr_fire) begin
            w_held_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= 2'h0;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= (awaddr_q == misc_ctrl_pkg::sysctl_off) ? 2'h0 : 2'h2;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // ====================================================================
    // system control register
    misc_ctrl_pkg::sysctl_t ctl_q;
    logic [2:0]             wrote_q;
    logic                   ctl_wr;
    logic                   anytime;

    assign ctl_wr  = wr_fire && wstrb0_q && (awaddr_q == misc_ctrl_pkg::sysctl_off);
    assign anytime = misc_ctrl_pkg::is_special(mode_q);

    // one write per field in normal modes, tracked per field
    always_ff @(posedge aclk) begin
        if (!aresetn || !rst_seen_q) begin
            ctl_q.external_stretch_field     <= misc_ctrl_pkg::stretch_rst;
            ctl_q.program_mem_high_half_only <= misc_ctrl_pkg::hhalf_rst;
            ctl_q.program_mem_map_enable     <=
                (aresetn && mode_s2_q == misc_ctrl_pkg::mode_special_test)
                    ? pmen_rst_test : pmen_rst_normal;
            wrote_q <= 3'h0;
        end else if (ctl_wr) begin
            if (anytime || !wrote_q[2]) begin
                ctl_q.external_stretch_field <= wdata_q[misc_ctrl_pkg::stretch_lsb +: 2];
                wrote_q[2]                   <= 1'b1;
            end
            if (anytime || !wrote_q[1]) begin
                ctl_q.program_mem_high_half_only <= wdata_q[misc_ctrl_pkg::hhalf_bit];
                wrote_q[1]                       <= 1'b1;
            end
            if (anytime || !wrote_q[0]) begin
                ctl_q.program_mem_map_enable <= wdata_q[misc_ctrl_pkg::pmen_bit];
                wrote_q[0]                   <= 1'b1;
            end
        end
    end

    // ====================================================================
    // axi4-lite read path
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;

    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rresp_q  <= 2'h0;
            unique case (s_axi_araddr)
                misc_ctrl_pkg::sysctl_off:
                    rdata_q <= {28'h0000000, ctl_q};
                misc_ctrl_pkg::access_off:
                    rdata_q <= {28'h0000000, bus_timing_clock, ext_access_busy,
                                misc_ctrl_pkg::has_ext_bus(mode_q), 1'b0};
                default: begin
                    rdata_q <= 32'h0000_0000;
                    rresp_q <= 2'h2;
                end
            endcase
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ====================================================================
    // memory map decode, registered fields so a write acts a cycle later
    assign program_mem_visible   = ctl_q.program_mem_map_enable;
    assign low_fixed_page_enable = ctl_q.program_mem_map_enable
                                 && !ctl_q.program_mem_high_half_only
                                 && low_fixed_page_hit;

    // ====================================================================
    // external access stretcher: a write of 1 to bit 0 of access_off starts one access when idle, in a mode with an external bus
    typedef enum logic [2:0] {
        st_idle  = 3'b001,
        st_low   = 3'b010,
        st_high  = 3'b100
    } acc_state_t;

    acc_state_t state_q;
    logic [1:0] stretch_cnt_q;
    logic       acc_start;

    assign acc_start = wr_fire && wstrb0_q && wdata_q[0]
                     && (awaddr_q == misc_ctrl_pkg::access_off)
                     && misc_ctrl_pkg::has_ext_bus(mode_q);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q       <= st_idle;
            stretch_cnt_q <= 2'h0;
        end else begin
            unique case (state_q)
                st_idle: if (acc_start) begin
                    state_q <= st_low;
                end
                st_low: begin
                    state_q       <= st_high;
                    stretch_cnt_q <= ctl_q.external_stretch_field;
                end
                st_high: if (stretch_cnt_q == 2'h0) begin
                    state_q <= st_idle;
                end else begin
                    stretch_cnt_q <= stretch_cnt_q - 2'h1;
                end
                default: state_q <= st_idle;
            endcase
        end
    end

    assign ext_access_busy  = (state_q != st_idle);
    assign bus_timing_clock = (state_q == st_high);

    // ====================================================================
    // checks
    sequence high_phase_s(int n);
        bus_timing_clock [*1] ##0 (stretch_cnt_q == 2'(n));
    endsequence

    stretch_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_q == st_low && ctl_q.external_stretch_field == 2'h3) |=>
            high_phase_s(3) ##1 high_phase_s(2) ##1 high_phase_s(1) ##1 high_phase_s(0)
            ##1 !bus_timing_clock)
        else $error("stretched high phase not four cycles");

    no_stretch_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_q == st_low && ctl_q.external_stretch_field == 2'h0) |=>
            bus_timing_clock ##1 !bus_timing_clock)
        else $error("unstretched high phase not one cycle");

    no_bus_idle_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !misc_ctrl_pkg::has_ext_bus(mode_q) && state_q == st_idle |=> state_q == st_idle)
        else $error("external access started without external bus");

    write_once_a: assert property (@(posedge aclk) disable iff (!aresetn || !rst_seen_q)
        (!anytime && wrote_q[0]) |=> $stable(ctl_q.program_mem_map_enable))
        else $error("enable field rewritten in normal mode");

    special_wr_a: assert property (@(posedge aclk) disable iff (!aresetn || !rst_seen_q)
        (anytime && ctl_wr) |=>
            ctl_q.external_stretch_field == $past(wdata_q[3:2]))
        else $error("special mode write not taken");

    delay_one_a: assert property (@(posedge aclk) disable iff (!aresetn || !rst_seen_q)
        (ctl_wr && anytime && wdata_q[0] != ctl_q.program_mem_map_enable) |->
            program_mem_visible == ctl_q.program_mem_map_enable ##1
            program_mem_visible == $past(wdata_q[0]))
        else $error("enable change not one cycle after write");

    low_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ctl_q.program_mem_high_half_only |-> !low_fixed_page_enable)
        else $error("low page reachable with high-half-only set");

    low_open_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (low_fixed_page_hit && ctl_q.program_mem_map_enable
         && !ctl_q.program_mem_high_half_only) |-> low_fixed_page_enable)
        else $error("low page blocked with high-half-only clear");

    map_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !ctl_q.program_mem_map_enable |-> !program_mem_visible && !low_fixed_page_enable)
        else $error("program memory visible while disabled");

    reset_val_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(rst_seen_q) |-> ctl_q.external_stretch_field == 2'h3
            && !ctl_q.program_mem_high_half_only)
        else $error("wrong reset value of stretch or half bit");

    test_rst_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ($rose(rst_seen_q) ##1 mode_q == misc_ctrl_pkg::mode_special_test && !wrote_q[0])
            |-> ctl_q.program_mem_map_enable == pmen_rst_test)
        else $error("enable reset value wrong in test mode");

    read_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == misc_ctrl_pkg::sysctl_off)
            |=> s_axi_rvalid && s_axi_rresp == 2'h0 && s_axi_rdata[31:4] == 28'h0000000)
        else $error("register read failed or upper bits set");

endmodule : system_misc_control

// ### src/misc_ctrl_pkg.sv
// package: register map, field layout, modes and reset values of the system control register
package misc_ctrl_pkg;

    // ====================================================================
    // register map
    localparam logic [3:0] sysctl_off = 4'h0;   // system_control_reg
    localparam logic [3:0] access_off = 4'h4;   // external access request/status

    // ====================================================================
    // field layout
    localparam int stretch_lsb = 2;
    localparam int hhalf_bit   = 1;
    localparam int pmen_bit    = 0;

    // ====================================================================
    // reset values
    localparam logic [1:0] stretch_rst = 2'h3;
    localparam logic       hhalf_rst   = 1'b0;

    // ====================================================================
    // operating modes, three mode pins
    typedef enum logic [2:0] {
        mode_special_single = 3'h0,
        mode_special_exp    = 3'h1,
        mode_special_periph = 3'h2,
        mode_special_test   = 3'h3,
        mode_normal_single  = 3'h4,
        mode_normal_exp_n   = 3'h5,
        mode_emul_exp_w     = 3'h6,
        mode_normal_exp_w   = 3'h7
    } op_mode_t;

    // ====================================================================
    // system control fields
    typedef struct packed {
        logic [1:0] external_stretch_field;
        logic       program_mem_high_half_only;
        logic       program_mem_map_enable;
    } sysctl_t;

    // special modes allow rewriting at any time
    function automatic logic is_special(input op_mode_t m);
        is_special = (m[2] == 1'b0);
    endfunction : is_special

    // single-chip and peripheral: no external bus
    function automatic logic has_ext_bus(input op_mode_t m);
        has_ext_bus = !(m == mode_special_single || m == mode_special_periph
                        || m == mode_normal_single);
    endfunction : has_ext_bus

endpackage : misc_ctrl_pkg

// ### test/system_misc_control_test.sv
// testbench: system control register driven over its axi4-lite port
`timescale 1ns/1ps
module system_misc_control_test;
    // ====================================================================
    // signals
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, hit;
    logic [2:0]  mode_pins;
    logic [3:0]  awaddr, wstrb, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp;
    logic        awready, wready, bvalid, arready, rvalid, visible, lfe, busy, tclk;
    int          n_fail, samples_checked, cycles;
    logic [31:0] v;
    logic [1:0]  r;
    int          hi, bz;
    int          hi_cnt, busy_cnt;

    system_misc_control i_system_misc_control (
        .aclk(aclk), .aresetn(aresetn), .mode_pins(mode_pins),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .low_fixed_page_hit(hit),
        .program_mem_visible(visible), .low_fixed_page_enable(lfe),
        .ext_access_busy(busy), .bus_timing_clock(tclk));

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // ====================================================================
    // tasks
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : check

    task automatic do_reset(input logic [2:0] m);
        aresetn   <= 1'b0;
        mode_pins <= m;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
    endtask : do_reset

    // address and data offered together, each released when taken
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] rs);
        logic aw_p, w_p, b_p;
        @(posedge aclk);
        aw_p = 1'b1;
        w_p  = 1'b1;
        b_p  = 1'b1;
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (b_p) begin
            @(posedge aclk);
            if (bvalid === 1'b1) begin
                rs  = bresp;
                b_p = 1'b0;
            end
            if (aw_p && awready === 1'b1) begin
                aw_p = 1'b0;
                awvalid <= 1'b0;
            end
            if (w_p && wready === 1'b1) begin
                w_p = 1'b0;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] rs);
        logic ar_p, r_p;
        @(posedge aclk);
        ar_p = 1'b1;
        r_p  = 1'b1;
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        while (r_p) begin
            @(posedge aclk);
            if (rvalid === 1'b1) begin
                d   = rdata;
                rs  = rresp;
                r_p = 1'b0;
            end
            if (ar_p && arready === 1'b1) begin
                ar_p = 1'b0;
                arvalid <= 1'b0;
            end
        end
        rready <= 1'b0;
    endtask : axi_read

    // counts run all the time, so the low phase that starts inside the write is seen too
    always @(posedge aclk) begin
        if (tclk === 1'b1) hi_cnt++;
        if (busy === 1'b1) busy_cnt++;
    end

    // requests one external access and counts high-phase and busy cycles
    task automatic run_access(output int h, output int b);
        logic [1:0] rs;
        hi_cnt   = 0;
        busy_cnt = 0;
        axi_write(4'h4, 32'h0000_0001, rs);
        repeat (12) @(posedge aclk);
        h = hi_cnt;
        b = busy_cnt;
    endtask : run_access

    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            print_verdict();
        end
    end

    // ====================================================================
    // tests
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, hit} = 7'h00;
        mode_pins = 3'h5;
        {awaddr, araddr, wstrb} = 12'h00F;
        wdata = 32'h0;
        n_fail = 0;
        samples_checked = 0;
        cycles = 0;
        hi_cnt = 0;
        busy_cnt = 0;
        // normal expanded mode: reset value, write-once, unmapped place
        do_reset(3'h5);
        axi_read(4'h0, v, r);
        check("ctl reset normal", v, 32'h0000_000D);
        axi_write(4'h0, 32'hFFFF_FFF2, r);
        check("write resp", {30'h0, r}, 32'h0);
        check("visible after write", {31'h0, visible}, 32'h0);
        axi_read(4'h0, v, r);
        check("ctl first write", v, 32'h0000_0002);
        hit <= 1'b1;
        @(posedge aclk);
        @(negedge aclk);
        check("low page map off", {31'h0, lfe}, 32'h0);
        axi_write(4'h0, 32'h0000_000D, r);
        axi_read(4'h0, v, r);
        check("ctl second write", v, 32'h0000_0002);
        run_access(hi, bz);
        check("high cycles s0", 32'(hi), 32'h1);
        check("busy s0", 32'(bz), 32'h2);
        axi_read(4'h4, v, r);
        check("access idle", v, 32'h0000_0002);
        axi_read(4'h8, v, r);
        check("unmapped rdata", v, 32'h0);
        check("unmapped rresp", {30'h0, r}, 32'h2);
        axi_write(4'h8, 32'h0000_0001, r);
        check("unmapped bresp", {30'h0, r}, 32'h2);
        $display("test normal mode done, mismatches %0d", n_fail);
        // special test mode: reset value, rewrite anytime, every stretch code
        do_reset(3'h3);
        axi_read(4'h0, v, r);
        check("ctl reset test", v, 32'h0000_000C);
        for (int s = 0; s < 4; s++) begin
            axi_write(4'h0, 32'(s * 4 + 1), r);
            axi_read(4'h0, v, r);
            check("ctl rewrite", v, 32'(s * 4 + 1));
            check("visible", {31'h0, visible}, 32'h1);
            check("low page open", {31'h0, lfe}, 32'h1);
            run_access(hi, bz);
            check("high cycles", 32'(hi), 32'(s + 1));
            check("busy cycles", 32'(bz), 32'(s + 2));
        end
        axi_write(4'h0, 32'h0000_0003, r);
        @(posedge aclk);
        @(negedge aclk);
        check("low page blocked", {31'h0, lfe}, 32'h0);
        check("visible high half", {31'h0, visible}, 32'h1);
        $display("test special mode done, mismatches %0d", n_fail);
        // special single-chip: stretch has no effect, no external access
        do_reset(3'h0);
        axi_read(4'h0, v, r);
        check("ctl reset single", v, 32'h0000_000D);
        axi_write(4'h0, 32'h0000_000D, r);
        run_access(hi, bz);
        check("single high", 32'(hi), 32'h0);
        check("single busy", 32'(bz), 32'h0);
        axi_read(4'h4, v, r);
        check("single access reg", v, 32'h0);
        $display("test single chip done, mismatches %0d", n_fail);
        print_verdict();
    end
endmodule : system_misc_control_test
